// ---- shared/csa_cfg.svh ----
`ifndef CSA_CFG_SVH
`define CSA_CFG_SVH

// i2c target and register map
`define CSA_I2C_ADDR        7'h3B
`define CSA_REG_BASE        16'h4000
`define CSA_IDX_CLK         2'h0
`define CSA_IDX_PORT        2'h1
`define CSA_IDX_WLEN        2'h2
`define CSA_IDX_BDIV        2'h3
// field positions
`define CSA_CLK_EN_BIT      0
`define CSA_PORT_MASTER_BIT 0
`define CSA_PORT_FMT_BIT    1
// reset values: converters off, clock slave, I2S, 24-bit words
`define CSA_CLK_RST         8'h00
`define CSA_PORT_RST        8'h00
`define CSA_WLEN_RST        8'h18
`define CSA_BDIV_RST        8'h10
// word length limits and slot size
`define CSA_WLEN_MIN        5'h10
`define CSA_WLEN_MAX        5'h18
`define CSA_SLOT_LAST       5'h1F
// timing
`define CSA_CLK_PERIOD_NS   10
`define CSA_MCLK_TIMEOUT_NS 1000
`define CSA_MCLK_TIMEOUT_CYC (`CSA_MCLK_TIMEOUT_NS / `CSA_CLK_PERIOD_NS)

`endif

// ---- shared/csa_pkg.sv ----
package csa_pkg;

  // i2c target phases
  typedef enum logic [4:0] {
    CSA_ST_IDLE = 5'h01,
    CSA_ST_RECV = 5'h02,
    CSA_ST_ACK  = 5'h04,
    CSA_ST_SEND = 5'h08,
    CSA_ST_MACK = 5'h10
  } csa_i2c_state_e;

  // serial framing choice
  typedef enum logic [0:0] {
    CSA_FMT_I2S = 1'h0,
    CSA_FMT_LJ  = 1'h1
  } csa_fmt_e;

endpackage

// ---- verilog/csa_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module csa_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // pins in, filtered levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  // a bit only moves once stages two and three agree, masking a late settle
  always_comb begin
    next_dout = (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/csa_codec_port.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csa_cfg.svh"

module csa_codec_port (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // master clock from the far logic
  input  wire logic        mclk,
  // serial audio port
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe,
  input  wire logic        lrclk_in,
  output logic             lrclk_out,
  output logic             lrclk_oe,
  input  wire logic        playback_serial_data,
  output logic             record_serial_data,
  // i2c configuration port, open drain
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // converter side
  input  wire logic [23:0] rec_left,
  input  wire logic [23:0] rec_right,
  output logic             rec_take,
  output logic [23:0]      play_sample,
  output logic             play_right,
  output logic             play_valid
);

  logic [5:0] pin_s;
  logic       mclk_s, bclk_s, lr_s, play_s, scl_s, sda_s;

  csa_pin_sync #(.W(6)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .din      ({mclk, bclk_in, lrclk_in, playback_serial_data, scl, sda_in}),
    .dout     (pin_s)
  );
  assign {mclk_s, bclk_s, lr_s, play_s, scl_s, sda_s} = pin_s;

  // ---- edge history and master clock watchdog
  logic [5:0] pin_p, next_pin_p;
  logic [7:0] mclk_cnt, next_mclk_cnt;
  logic       mclk_active, next_mclk_active;

  // a stalled master clock sends the i2c target to idle and stops the audio port; registers keep their values
  always_comb begin
    next_pin_p       = pin_s;
    next_mclk_cnt    = mclk_cnt;
    next_mclk_active = mclk_active;
    if (mclk_s != pin_p[5]) begin
      next_mclk_cnt    = 8'h00;
      next_mclk_active = 1'b1;
    end else if (mclk_cnt == 8'(`CSA_MCLK_TIMEOUT_CYC - 1)) begin
      next_mclk_active = 1'b0;
    end else begin
      next_mclk_cnt = mclk_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_p       <= 6'h00;
      mclk_cnt    <= 8'h00;
      mclk_active <= 1'b0;
    end else begin
      pin_p       <= next_pin_p;
      mclk_cnt    <= next_mclk_cnt;
      mclk_active <= next_mclk_active;
    end
  end

  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_rise  = scl_s & ~pin_p[1];
  assign scl_fall  = ~scl_s & pin_p[1];
  assign i2c_start = scl_s & pin_p[1] & pin_p[0] & ~sda_s;
  assign i2c_stop  = scl_s & pin_p[1] & ~pin_p[0] & sda_s;

  // ---- i2c target and register file
  csa_pkg::csa_i2c_state_e st, next_st;
  logic [3:0]  bitc, next_bitc;
  logic [1:0]  bidx, next_bidx;
  logic        rw, next_rw;
  logic [7:0]  sh, next_sh;
  logic [15:0] raddr, next_raddr;
  logic        sda_drv, next_sda_drv;
  logic [7:0]  regs [4];
  logic [7:0]  next_regs [4];
  logic        reg_hit;
  logic [7:0]  rd_byte;

  // only this small window of the map exists; other reads return zero
  assign reg_hit = raddr[15:2] == 14'(`CSA_REG_BASE >> 2);
  assign rd_byte = reg_hit ? regs[raddr[1:0]] : 8'h00;

  always_comb begin
    next_st      = st;
    next_bitc    = bitc;
    next_bidx    = bidx;
    next_rw      = rw;
    next_sh      = sh;
    next_raddr   = raddr;
    next_sda_drv = sda_drv;
    next_regs    = regs;
    if (!mclk_active) begin
      next_st      = csa_pkg::CSA_ST_IDLE;
      next_sda_drv = 1'b0;
    end else if (i2c_start) begin
      next_st      = csa_pkg::CSA_ST_RECV;
      next_bitc    = 4'h0;
      next_bidx    = 2'h0;
      next_sda_drv = 1'b0;
    end else if (i2c_stop) begin
      next_st      = csa_pkg::CSA_ST_IDLE;
      next_sda_drv = 1'b0;
    end else begin
      case (st)
        csa_pkg::CSA_ST_RECV: begin
          if (scl_rise && bitc != 4'h8) begin
            next_sh   = {sh[6:0], sda_s};
            next_bitc = bitc + 4'h1;
          end else if (scl_fall && bitc == 4'h8) begin
            next_bitc    = 4'h0;
            next_bidx    = (bidx == 2'h3) ? bidx : bidx + 2'h1;
            next_st      = csa_pkg::CSA_ST_ACK;
            next_sda_drv = 1'b1;
            if (bidx == 2'h0) begin
              next_rw = sh[0];
              if (sh[7:1] != `CSA_I2C_ADDR) begin
                next_st      = csa_pkg::CSA_ST_IDLE;
                next_sda_drv = 1'b0;
              end
            end else if (bidx == 2'h1) begin
              next_raddr[15:8] = sh;
            end else if (bidx == 2'h2) begin
              next_raddr[7:0] = sh;
            end else begin
              if (reg_hit) begin
                next_regs[raddr[1:0]] = sh;
              end
              next_raddr = raddr + 16'h0001;
            end
          end
        end
        csa_pkg::CSA_ST_ACK: begin
          if (scl_fall) begin
            next_sda_drv = 1'b0;
            next_st      = csa_pkg::CSA_ST_RECV;
            if (rw && bidx == 2'h1) begin
              next_st      = csa_pkg::CSA_ST_SEND;
              next_sda_drv = ~rd_byte[7];
              next_sh      = {rd_byte[6:0], 1'b0};
              next_bitc    = 4'h1;
              next_raddr   = raddr + 16'h0001;
            end
          end
        end
        csa_pkg::CSA_ST_SEND: begin
          if (scl_fall) begin
            if (bitc == 4'h8) begin
              next_sda_drv = 1'b0;
              next_st      = csa_pkg::CSA_ST_MACK;
            end else begin
              next_sda_drv = ~sh[7];
              next_sh      = {sh[6:0], 1'b0};
              next_bitc    = bitc + 4'h1;
            end
          end
        end
        csa_pkg::CSA_ST_MACK: begin
          // a not-acknowledge ends the read; an ack reloads on the fall
          if (scl_rise && sda_s) begin
            next_st = csa_pkg::CSA_ST_IDLE;
          end else if (scl_fall) begin
            next_st      = csa_pkg::CSA_ST_SEND;
            next_sda_drv = ~rd_byte[7];
            next_sh      = {rd_byte[6:0], 1'b0};
            next_bitc    = 4'h1;
            next_raddr   = raddr + 16'h0001;
          end
        end
        default: begin
          next_st = csa_pkg::CSA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st                  <= csa_pkg::CSA_ST_IDLE;
      bitc                <= 4'h0;
      bidx                <= 2'h0;
      rw                  <= 1'b0;
      sh                  <= 8'h00;
      raddr               <= 16'h0000;
      sda_drv             <= 1'b0;
      regs[`CSA_IDX_CLK]  <= `CSA_CLK_RST;
      regs[`CSA_IDX_PORT] <= `CSA_PORT_RST;
      regs[`CSA_IDX_WLEN] <= `CSA_WLEN_RST;
      regs[`CSA_IDX_BDIV] <= `CSA_BDIV_RST;
    end else begin
      st      <= next_st;
      bitc    <= next_bitc;
      bidx    <= next_bidx;
      rw      <= next_rw;
      sh      <= next_sh;
      raddr   <= next_raddr;
      sda_drv <= next_sda_drv;
      regs    <= next_regs;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_drv;

  // ---- configuration decode
  logic       run, master, fmt_i2s;
  logic [4:0] wlen;
  assign run     = regs[`CSA_IDX_CLK][`CSA_CLK_EN_BIT] & mclk_active;
  assign master  = regs[`CSA_IDX_PORT][`CSA_PORT_MASTER_BIT];
  assign fmt_i2s = regs[`CSA_IDX_PORT][`CSA_PORT_FMT_BIT] == csa_pkg::CSA_FMT_I2S;
  // out-of-range lengths clamp to 16..24 bits
  assign wlen = (regs[`CSA_IDX_WLEN] >= 8'h18) ? `CSA_WLEN_MAX :
                (regs[`CSA_IDX_WLEN] < 8'h10) ? `CSA_WLEN_MIN : regs[`CSA_IDX_WLEN][4:0];

  // ---- bit and frame clock generator for master mode
  logic [7:0] bdiv_cnt, next_bdiv_cnt;
  logic       bclk_gen, next_bclk_gen;
  logic [4:0] slot, next_slot;
  logic       lr_gen, next_lr_gen;
  logic       tick;
  assign tick = run & master & (bdiv_cnt == 8'h00);

  // frame clock turns on the bit clock fall, every 32 bits
  always_comb begin
    next_bdiv_cnt = tick ? regs[`CSA_IDX_BDIV] : bdiv_cnt - 8'h01;
    next_bclk_gen = tick ? ~bclk_gen : bclk_gen;
    next_slot     = slot;
    next_lr_gen   = lr_gen;
    if (!(run && master)) begin
      next_bdiv_cnt = 8'h00;
      next_bclk_gen = 1'b0;
    end else if (tick && bclk_gen) begin
      next_slot = slot + 5'h01;
      if (slot == `CSA_SLOT_LAST) begin
        next_lr_gen = ~lr_gen;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bdiv_cnt <= 8'h00;
      bclk_gen <= 1'b0;
      slot     <= 5'h00;
      lr_gen   <= 1'b0;
    end else begin
      bdiv_cnt <= next_bdiv_cnt;
      bclk_gen <= next_bclk_gen;
      slot     <= next_slot;
      lr_gen   <= next_lr_gen;
    end
  end

  assign bclk_out  = bclk_gen;
  assign lrclk_out = lr_gen;
  assign bclk_oe   = run & master;
  assign lrclk_oe  = run & master;

  // ---- serial data engine
  logic rise_ev, fall_ev, lr_r, lr_f;
  assign rise_ev = master ? (tick & ~bclk_gen) : (run & bclk_s & ~pin_p[4]);
  assign fall_ev = master ? (tick & bclk_gen) : (run & ~bclk_s & pin_p[4]);
  assign lr_r    = master ? lr_gen : lr_s;
  assign lr_f    = master ? next_lr_gen : lr_s;

  logic        lr_rlast, next_lr_rlast, lr_flast, next_lr_flast;
  logic [5:0]  pos, next_pos, pos_new, dly, wend;
  logic [23:0] rx, next_rx, tx, next_tx, tx_load;
  logic        next_rec_sd, next_rec_take, next_play_right, next_play_valid;
  logic [23:0] next_play_sample;
  assign dly     = {5'h00, fmt_i2s};
  assign wend    = dly + {1'b0, wlen};
  assign tx_load = (lr_f ? rec_right : rec_left) & ~(24'hFFFFFF >> wlen);

  always_comb begin
    next_lr_rlast    = lr_rlast;
    next_lr_flast    = lr_flast;
    next_pos         = pos;
    next_rx          = rx;
    next_tx          = tx;
    next_rec_sd      = record_serial_data;
    next_play_sample = play_sample;
    next_play_right  = play_right;
    next_play_valid  = 1'b0;
    next_rec_take    = 1'b0;
    pos_new          = (lr_r != lr_rlast) ? 6'h00 : ((pos == 6'h3F) ? pos : pos + 6'h01);
    if (!run) begin
      next_rec_sd = 1'b0;
      next_pos    = 6'h00;
    end else begin
      // playback bits sampled on the rise, msb first
      if (rise_ev) begin
        next_lr_rlast = lr_r;
        next_pos      = pos_new;
        if (pos_new >= dly && pos_new < wend) begin
          next_rx = {rx[22:0], play_s};
        end
        if (pos_new == wend - 6'h01) begin
          next_play_sample = {rx[22:0], play_s} << 5'(`CSA_WLEN_MAX - wlen);
          next_play_right  = lr_r; // high means right channel
          next_play_valid  = 1'b1;
        end
      end
      // record bits launched on the fall so they settle before the rise
      if (fall_ev) begin
        next_lr_flast = lr_f;
        if (lr_f != lr_flast) begin
          next_rec_take = 1'b1;
          if (fmt_i2s) begin
            next_rec_sd = 1'b0;
            next_tx     = tx_load;
          end else begin
            next_rec_sd = tx_load[23];
            next_tx     = {tx_load[22:0], 1'b0};
          end
        end else begin
          next_rec_sd = tx[23];
          next_tx     = {tx[22:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lr_rlast           <= 1'b0;
      lr_flast           <= 1'b0;
      pos                <= 6'h00;
      rx                 <= 24'h000000;
      tx                 <= 24'h000000;
      record_serial_data <= 1'b0;
      rec_take           <= 1'b0;
      play_sample        <= 24'h000000;
      play_right         <= 1'b0;
      play_valid         <= 1'b0;
    end else begin
      lr_rlast           <= next_lr_rlast;
      lr_flast           <= next_lr_flast;
      pos                <= next_pos;
      rx                 <= next_rx;
      tx                 <= next_tx;
      record_serial_data <= next_rec_sd;
      rec_take           <= next_rec_take;
      play_sample        <= next_play_sample;
      play_right         <= next_play_right;
      play_valid         <= next_play_valid;
    end
  end

  // ---- checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence addr_byte_done;
    st == csa_pkg::CSA_ST_RECV && bidx == 2'h0 && bitc == 4'h8 && scl_fall
      && !i2c_start && !i2c_stop && mclk_active;
  endsequence

  a_foreign_addr_ignored: assert property (
    addr_byte_done and (sh[7:1] != `CSA_I2C_ADDR) |=> st == csa_pkg::CSA_ST_IDLE && !sda_oe)
    else $error("foreign target address was answered");
  a_own_addr_acked: assert property (
    addr_byte_done and (sh[7:1] == `CSA_I2C_ADDR) |=> st == csa_pkg::CSA_ST_ACK && sda_oe)
    else $error("own target address not acknowledged");
  a_mclk_stop_idle: assert property (
    !mclk_active |-> !bclk_oe ##1 (st == csa_pkg::CSA_ST_IDLE && !sda_oe))
    else $error("activity without master clock");
  a_slave_clock_free: assert property (
    !master |-> !bclk_oe && !lrclk_oe)
    else $error("clock pins driven in slave mode");
  a_frame_on_fall: assert property (
    $changed(lrclk_out) && bclk_oe |-> $fell(bclk_out))
    else $error("frame clock moved off the bit clock fall");
  a_i2s_delay_bit: assert property (
    fall_ev && fmt_i2s && lr_f != lr_flast |=> !record_serial_data ##0 $past(tx_load) == tx)
    else $error("i2s delay bit missing");
  a_play_word_pulse: assert property (
    play_valid |-> $past(rise_ev) ##1 !play_valid)
    else $error("playback strobe malformed");
  a_ack_released: assert property (
    st == csa_pkg::CSA_ST_ACK && scl_fall && mclk_active && !i2c_start && !i2c_stop
      |=> st != csa_pkg::CSA_ST_ACK)
    else $error("ack held past its clock");

endmodule

`default_nettype wire

// ---- verif/csa_far_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// far logic: master clock, i2c controller and slave-mode audio source
module csa_far_model (
  // pacing clock
  input  wire logic core_clk,
  // pin levels seen from the far side
  input  wire logic sda_level,
  input  wire logic rec_level,
  // pins driven from the far side
  output var logic  mclk,
  output var logic  scl,
  output var logic  sda_low,
  output var logic  bclk,
  output var logic  lrclk,
  output var logic  pb_data
);
  logic mclk_run;

  // idle levels; the bit clock stands still between frames
  initial begin
    mclk_run = 1'b1;
    mclk = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
    bclk = 1'b1;
    lrclk = 1'b1;
    pb_data = 1'b0;
  end

  // master clock on the bench grid, nearest to 12 MHz; stops only on command
  always begin
    repeat (4) @(negedge core_clk);
    if (mclk_run) mclk = ~mclk;
  end

  // one scl period; sda moves only well inside scl low so no false start
  task automatic i2c_bit(input logic drive_low, output logic level);
    repeat (5) @(negedge core_clk);
    sda_low = drive_low;
    repeat (20) @(negedge core_clk);
    scl = 1'b1;
    repeat (25) @(negedge core_clk);
    level = sda_level;
    scl = 1'b0;
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic i2c_start();
    repeat (5) @(negedge core_clk);
    sda_low = 1'b0;
    repeat (20) @(negedge core_clk);
    scl = 1'b1;
    repeat (25) @(negedge core_clk);
    sda_low = 1'b1;
    repeat (25) @(negedge core_clk);
    scl = 1'b0;
  endtask

  // stop: sda rises while scl is high
  task automatic i2c_stop();
    repeat (5) @(negedge core_clk);
    sda_low = 1'b1;
    repeat (20) @(negedge core_clk);
    scl = 1'b1;
    repeat (25) @(negedge core_clk);
    sda_low = 1'b0;
    repeat (25) @(negedge core_clk);
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic i2c_byte(input logic [7:0] tx, input logic mack,
                          output logic [7:0] rx, output logic acked);
    logic lv;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(~tx[i], lv);
      rx[i] = lv;
    end
    i2c_bit(mack, lv);
    acked = ~lv;
  endtask

  // one 32-bit channel slot, bit clock driven from here by default
  task automatic send_chan(input logic ch, input logic [23:0] w, input int dly,
                           output logic [31:0] rec);
    // 125 ns bit period, started 1 ns past a fall so no change meets a rising edge
    @(negedge core_clk);
    #1;
    for (int j = 0; j < 32; j++) begin
      bclk = 1'b0;
      if (j == 0) lrclk = ch; // frame edge with the fall, low left
      if (j >= dly && j < dly + 24) pb_data = w[23 - (j - dly)]; // msb first
      else pb_data = ~pb_data; // idle bits never repeat a stale value
      #62;
      bclk = 1'b1;
      #63;
      rec[31 - j] = rec_level;
    end
    // back on the falling-edge grid before the bench moves its inputs
    @(negedge core_clk);
  endtask
endmodule

`default_nettype wire

// ---- verif/csa_codec_port_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module csa_codec_port_tb_top;
  // design pins and bench state
  logic        core_clk;
  logic        reset;
  logic [23:0] rec_left;
  logic [23:0] rec_right;
  wire logic   mclk, scl, sda_low, bclk_far, lrclk_far, pb_data, sda_out, sda_oe;
  wire logic   bclk_out, bclk_oe, lrclk_out, lrclk_oe, record_serial_data;
  wire logic   rec_take, play_right, play_valid;
  wire logic [23:0] play_sample;
  logic [24:0] exp_q[$];
  logic [24:0] note;
  logic [7:0]  rx_byte;
  logic        acked;
  logic        pb_watch;
  int          seed;
  int          n_tests;
  int          err_total;
  int          takes;
  int          wl;
  time         t0;

  // open-drain sda with pull-up; shared clocks follow whoever enables them
  wire logic sda_level = !(sda_low || (sda_oe && !sda_out));
  wire logic bclk_pin  = bclk_oe ? bclk_out : bclk_far;
  wire logic lrclk_pin = lrclk_oe ? lrclk_out : lrclk_far;

  csa_codec_port csa_codec_port_i (.core_clk(core_clk), .reset(reset), .mclk(mclk),
    .bclk_in(bclk_pin), .bclk_out(bclk_out), .bclk_oe(bclk_oe), .lrclk_in(lrclk_pin),
    .lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe), .playback_serial_data(pb_data),
    .record_serial_data(record_serial_data), .scl(scl), .sda_in(sda_level),
    .sda_out(sda_out), .sda_oe(sda_oe), .rec_left(rec_left), .rec_right(rec_right),
    .rec_take(rec_take), .play_sample(play_sample), .play_right(play_right),
    .play_valid(play_valid));

  csa_far_model csa_far_model_i (.core_clk(core_clk), .sda_level(sda_level),
    .rec_level(record_serial_data), .mclk(mclk), .scl(scl), .sda_low(sda_low),
    .bclk(bclk_far), .lrclk(lrclk_far), .pb_data(pb_data));

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one byte on the bus; only the target ack slot is judged
  task automatic i2c_xfer(input logic [7:0] b, input logic exp_ack);
    csa_far_model_i.i2c_byte(b, 1'b0, rx_byte, acked);
    check("target ack", acked, exp_ack);
  endtask

  // register write: target, address high, address low, data
  task automatic reg_write(input logic [6:0] dev, input logic [15:0] ra,
                           input logic [7:0] d, input logic ok);
    csa_far_model_i.i2c_start();
    i2c_xfer({dev, 1'b0}, ok);
    if (ok) begin
      i2c_xfer(ra[15:8], 1'b1);
      i2c_xfer(ra[7:0], 1'b1);
      i2c_xfer(d, 1'b1);
    end
    csa_far_model_i.i2c_stop();
  endtask

  // two-byte read across the auto-increment, repeated start keeps the address
  task automatic reg_read();
    csa_far_model_i.i2c_start();
    i2c_xfer(8'h76, 1'b1);
    i2c_xfer(8'h40, 1'b1);
    i2c_xfer(8'h02, 1'b1);
    csa_far_model_i.i2c_start();
    i2c_xfer(8'h77, 1'b1);
    csa_far_model_i.i2c_byte(8'hFF, 1'b1, rx_byte, acked);
    check("word length reset", rx_byte, 8'h18);
    csa_far_model_i.i2c_byte(8'hFF, 1'b0, rx_byte, acked);
    check("divider reset", rx_byte, 8'h10);
    csa_far_model_i.i2c_stop();
  endtask

  // one channel slot; mode 0 warms up, 1 expects data, 2 expects silence
  task automatic chan(input logic ch, input logic [23:0] w, input int dly, input int mode);
    logic [31:0] got;
    logic [31:0] expr;
    logic [23:0] wr;
    wr = ch ? rec_right : rec_left;
    expr = 32'h0;
    for (int k = 0; k < wl; k++) expr[31 - dly - k] = wr[23 - k];
    if (mode == 2) expr = 32'h0;
    if (mode == 1) exp_q.push_back({ch, w & ~(24'hFFFFFF >> wl)});
    pb_watch = (mode != 0);
    takes = 0;
    csa_far_model_i.send_chan(ch, w, dly, got);
    if (mode != 0) check("record word", got, expr);
    if (mode != 0) check("record take", takes, 32'(mode == 1));
  endtask

  // stereo frame with fresh random words both ways
  task automatic pair(input int dly);
    rec_left = 24'($random(seed));
    rec_right = 24'($random(seed));
    chan(1'b0, 24'($random(seed)), dly, 1);
    chan(1'b1, 24'($random(seed)), dly, 1);
  endtask

  // pops the oldest playback note for every valid pulse while pb_watch is set
  always @(negedge core_clk) begin
    if (rec_take === 1'b1) takes++;
    if (pb_watch && play_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected play_valid", 32'h1, 32'h0);
      end else begin
        note = exp_q.pop_front();
        check("play_right", play_right, note[24]);
        check("play_sample", play_sample, note[23:0]);
      end
    end
  end

  // watchdog well beyond the expected run of about 23k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    $display("watchdog expired");
    print_verdict();
  end

  // main sequence
  initial begin
    reset = 1'b1;
    rec_left = 24'h0;
    rec_right = 24'h0;
    pb_watch = 1'b0;
    seed = 59;
    n_tests = 0;
    err_total = 0;
    takes = 0;
    wl = 24;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    repeat (20) @(negedge core_clk); // master clock runs before configuration
    check("bclk_oe", bclk_oe, 1'b0);
    check("lrclk_oe", lrclk_oe, 1'b0);
    check("sda_oe", sda_oe, 1'b0);
    check("record line", record_serial_data, 1'b0);
    done("reset");
    reg_write(7'h3C, 16'h4000, 8'h01, 1'b0);
    reg_read();
    done("i2c");
    chan(1'b0, 24'hA5A5A5, 1, 2);
    done("disabled");
    reg_write(7'h3B, 16'h4000, 8'h01, 1'b1);
    chan(1'b1, 24'h0, 1, 0);
    repeat (2) pair(1);
    done("i2s slave");
    reg_write(7'h3B, 16'h4001, 8'h02, 1'b1);
    chan(1'b1, 24'h0, 0, 0);
    pair(0);
    done("left justified");
    reg_write(7'h3B, 16'h4002, 8'h10, 1'b1);
    wl = 16;
    pair(0);
    done("short word");
    // master frames carry no queued notes, so stop judging playback
    pb_watch = 1'b0;
    reg_write(7'h3B, 16'h4001, 8'h01, 1'b1);
    repeat (50) @(negedge core_clk);
    check("bclk_oe", bclk_oe, 1'b1);
    check("lrclk_oe", lrclk_oe, 1'b1);
    @(posedge bclk_out) t0 = $time;
    @(posedge bclk_out) check("bclk period", 32'(($time - t0) / 10), 32'h22);
    @(lrclk_out) t0 = $time;
    @(lrclk_out) check("frame half", 32'(($time - t0) / 10), 32'h440);
    done("master");
    reg_write(7'h3B, 16'h4001, 8'h00, 1'b1);
    csa_far_model_i.mclk_run = 1'b0;
    repeat (150) @(negedge core_clk);
    reg_write(7'h3B, 16'h4000, 8'h01, 1'b0);
    chan(1'b0, 24'h5A5A5A, 1, 2);
    csa_far_model_i.mclk_run = 1'b1;
    repeat (20) @(negedge core_clk);
    reg_write(7'h3B, 16'h4000, 8'h01, 1'b1);
    done("mclk stall");
    check("pending notes", exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule

`default_nettype wire
